// ==== asl_map.svh ====
// register offsets, reset values, frame bytes and reply layout of the station link responder
`ifndef ASL_MAP_SVH
`define ASL_MAP_SVH
`define ASL_OFF_CTRL     8'h00
`define ASL_OFF_CONC     8'h04
`define ASL_OFF_FAIL     8'h08
`define ASL_OFF_STATUS   8'h0C
`define ASL_RST_CTRL     32'h0000_0000
`define ASL_RST_CONC     26'h000_0000
`define ASL_RST_FAIL     8'h00
`define ASL_FAIL_MASK    8'h2B
`define ASL_CTRL_ID_LSB  0
`define ASL_CTRL_UNITS   12
`define ASL_CTRL_OOS     13
`define ASL_STAT_BG_CLR  0
`define ASL_BYTE_STX     8'h02
`define ASL_BYTE_ETX     8'h03
`define ASL_BYTE_SP      8'h20
`define ASL_BYTE_ZERO    8'h30
`define ASL_BYTE_PLUS    8'h2B
`define ASL_BYTE_MINUS   8'h2D
`define ASL_CH_A         8'h41
`define ASL_CH_D         8'h44
`define ASL_CH_K         8'h4B
`define ASL_CH_M         8'h4D
`define ASL_CH_N         8'h4E
`define ASL_CH_S         8'h53
`define ASL_CH_T         8'h54
`define ASL_CHAN_COUNT   8'h31
`define ASL_BCC_INIT     8'h00
`define ASL_TEXT_MAX     7'd120
`define ASL_LEN_DA_NOID  7'd2
`define ASL_LEN_DA_ID    7'd5
`define ASL_LEN_ST       7'd7
`define ASL_NOID_SKIP    6'd4
`define ASL_POS_ID       6'd6
`define ASL_POS_ETX      6'd37
`define ASL_POS_LAST     6'd39
`endif

// ==== asl_pkg.sv ====
// types shared by the station link responder
package asl_pkg;
    typedef enum logic [5:0] {
        ASL_IDLE  = 6'b000001,
        ASL_TEXT  = 6'b000010,
        ASL_CHK_H = 6'b000100,
        ASL_CHK_L = 6'b001000,
        ASL_EXEC  = 6'b010000,
        ASL_REPLY = 6'b100000
    } asl_state_e;
    typedef enum logic [1:0] {
        ASL_MEASURE = 2'b00,
        ASL_ZERO    = 2'b01,
        ASL_SPAN    = 2'b10
    } asl_mode_e;
    // concentration as software loads it: signs and bcd digits
    typedef struct packed {
        logic        exp_neg;
        logic [7:0]  exp_bcd;
        logic        mant_neg;
        logic [15:0] mant_bcd;
    } asl_conc_s;
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } asl_byte_s;
endpackage : asl_pkg

// ==== asl_responder.sv ====
// station link responder: frame parser, command decoder, reply generator, apb registers
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/100ps
`include "asl_map.svh"
module asl_responder (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire asl_pkg::asl_byte_s rx,
    output asl_pkg::asl_byte_s     tx,
    input  wire logic              tx_ready
);
    ////////////////////////////////////////////////////////////////////////////
    asl_pkg::asl_state_e state;
    asl_pkg::asl_mode_e  mode;
    asl_pkg::asl_conc_s  conc;
    asl_pkg::asl_conc_s  snap_conc;
    logic [31:0] ctrl;
    logic [7:0]  fail;
    logic [7:0]  bcc;
    logic [7:0]  tx_bcc;
    logic [6:0]  text_len;
    logic [7:0]  text_buf [0:6];
    logic [7:0]  chk_hi;
    logic [7:0]  drop_count;
    logic        bg_run;
    logic        no_id;
    logic [5:0]  tx_idx;
    logic [7:0]  snap_stat;
    logic [7:0]  snap_fail;
    logic [11:0] snap_id;
    logic        apb_setup;
    logic        apb_wr;
    logic        bg_clr;
    logic        bg_set;
    logic [7:0]  status_byte;
    logic [11:0] station_id;
    logic        id_ok;
    logic        check_ok;
    logic        is_da;
    logic        is_st;
    logic        accept;
    logic [4:0]  nib_hi;
    logic [4:0]  nib_lo;
    logic [5:0]  pos;
    logic [7:0]  next_tx_byte;
    logic        tx_take;

    function automatic logic [7:0] hex_char(input logic [3:0] n);
        hex_char = (n < 4'hA) ? (`ASL_BYTE_ZERO + {4'h0, n}) : (`ASL_CH_A + {4'h0, n} - 8'h0A);
    endfunction : hex_char

    // bit 4 set marks a character that is no upper-case hex digit
    function automatic logic [4:0] hex_val(input logic [7:0] c);
        if (c >= `ASL_BYTE_ZERO && c <= 8'h39) begin
            hex_val = {1'b0, c[3:0]};
        end else if (c >= `ASL_CH_A && c <= 8'h46) begin
            hex_val = {1'b0, c[3:0] + 4'h9};
        end else begin
            hex_val = 5'h10;
        end
    endfunction : hex_val

    function automatic logic [7:0] dig(input logic [3:0] d);
        dig = `ASL_BYTE_ZERO + {4'h0, d};
    endfunction : dig

    function automatic logic [7:0] sign(input logic neg);
        sign = neg ? `ASL_BYTE_MINUS : `ASL_BYTE_PLUS;
    endfunction : sign

    ////////////////////////////////////////////////////////////////////////////
    // apb slave, zero wait states: read data is captured in the setup cycle
    assign apb_setup = psel & ~penable;
    assign apb_wr    = psel & penable & pwrite;
    assign pready    = 1'b1;
    assign station_id = ctrl[`ASL_CTRL_ID_LSB +: 12];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (apb_setup) begin
            pslverr <= 1'b0;
            case (paddr)
                `ASL_OFF_CTRL:   prdata <= ctrl;
                `ASL_OFF_CONC:   prdata <= {6'h00, conc};
                `ASL_OFF_FAIL:   prdata <= {24'h000000, fail};
                `ASL_OFF_STATUS: prdata <= {8'h00, drop_count, 6'h00, mode, status_byte};
                default: begin
                    prdata  <= 32'h0000_0000;
                    pslverr <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `ASL_RST_CTRL;
            conc <= `ASL_RST_CONC;
            fail <= `ASL_RST_FAIL;
        end else if (apb_wr) begin
            if (paddr == `ASL_OFF_CTRL) begin
                ctrl <= {18'h0, pwdata[13:0]};
            end
            if (paddr == `ASL_OFF_CONC) begin
                conc <= pwdata[25:0];
            end
            if (paddr == `ASL_OFF_FAIL) begin
                fail <= pwdata[7:0] & `ASL_FAIL_MASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status byte assembly
    assign status_byte = {bg_run,
                          ctrl[`ASL_CTRL_UNITS],
                          2'b00,
                          mode == asl_pkg::ASL_SPAN,
                          mode == asl_pkg::ASL_ZERO,
                          ctrl[`ASL_CTRL_OOS],
                          1'b0};

    // background flag: software ends the check by writing one; a new start wins
    assign bg_clr = apb_wr && paddr == `ASL_OFF_STATUS && pwdata[`ASL_STAT_BG_CLR];
    assign bg_set = accept && is_st && text_buf[6] == `ASL_CH_S;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bg_run <= 1'b0;
        end else if (bg_set) begin
            bg_run <= 1'b1;
        end else if (bg_clr) begin
            bg_run <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame decode, evaluated in the chk_l cycle as the last check character arrives
    assign nib_hi   = hex_val(chk_hi);
    assign nib_lo   = hex_val(rx.data);
    assign id_ok    = text_buf[2] == dig(station_id[11:8]) &&
                      text_buf[3] == dig(station_id[7:4]) &&
                      text_buf[4] == dig(station_id[3:0]);
    assign check_ok = !nib_hi[4] && !nib_lo[4] && {nib_hi[3:0], nib_lo[3:0]} == bcc;
    assign is_da    = text_buf[0] == `ASL_CH_D && text_buf[1] == `ASL_CH_A &&
                      (text_len == `ASL_LEN_DA_NOID ||
                       (text_len == `ASL_LEN_DA_ID && id_ok));
    assign is_st    = text_buf[0] == `ASL_CH_S && text_buf[1] == `ASL_CH_T &&
                      text_len == `ASL_LEN_ST && id_ok &&
                      text_buf[5] == `ASL_BYTE_SP &&
                      (text_buf[6] == `ASL_CH_M || text_buf[6] == `ASL_CH_N ||
                       text_buf[6] == `ASL_CH_K || text_buf[6] == `ASL_CH_S);
    // last check character arrives in chk_l state; decision made on that byte
    assign accept   = state == asl_pkg::ASL_CHK_L && rx.valid && check_ok &&
                      text_len <= `ASL_TEXT_MAX;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= asl_pkg::ASL_MEASURE;
        end else if (accept && is_st) begin
            case (text_buf[6])
                `ASL_CH_M: mode <= asl_pkg::ASL_MEASURE;
                `ASL_CH_N: mode <= asl_pkg::ASL_ZERO;
                `ASL_CH_K: mode <= asl_pkg::ASL_SPAN;
                default:   mode <= mode;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drop_count <= 8'h00;
        end else if (state == asl_pkg::ASL_CHK_L && rx.valid && !(accept && (is_da || is_st))) begin
            drop_count <= drop_count + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive framing and reply sequencing
    assign tx_take = !tx.valid || tx_ready;
    assign pos     = (no_id && tx_idx >= `ASL_POS_ID) ? tx_idx + `ASL_NOID_SKIP : tx_idx;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state    <= asl_pkg::ASL_IDLE;
            bcc      <= `ASL_BCC_INIT;
            text_len <= 7'd0;
            chk_hi   <= 8'h00;
            no_id    <= 1'b0;
            for (int i = 0; i < 7; i++) begin
                text_buf[i] <= 8'h00;
            end
        end else begin
            case (state)
                asl_pkg::ASL_IDLE: begin
                    if (rx.valid && rx.data == `ASL_BYTE_STX) begin
                        state    <= asl_pkg::ASL_TEXT;
                        bcc      <= `ASL_BCC_INIT ^ `ASL_BYTE_STX;
                        text_len <= 7'd0;
                    end
                end
                asl_pkg::ASL_TEXT: begin
                    if (rx.valid) begin
                        if (rx.data == `ASL_BYTE_STX) begin
                            bcc      <= `ASL_BCC_INIT ^ `ASL_BYTE_STX;
                            text_len <= 7'd0;
                        end else if (rx.data == `ASL_BYTE_ETX) begin
                            bcc   <= bcc ^ rx.data;
                            state <= asl_pkg::ASL_CHK_H;
                        end else begin
                            bcc <= bcc ^ rx.data;
                            if (text_len < 7'd7) begin
                                text_buf[text_len[2:0]] <= rx.data;
                            end
                            // saturate just past the limit so overlong text stays marked
                            if (text_len <= `ASL_TEXT_MAX) begin
                                text_len <= text_len + 7'd1;
                            end
                        end
                    end
                end
                asl_pkg::ASL_CHK_H: begin
                    if (rx.valid) begin
                        chk_hi <= rx.data;
                        state  <= asl_pkg::ASL_CHK_L;
                    end
                end
                asl_pkg::ASL_CHK_L: begin
                    if (rx.valid) begin
                        no_id <= text_len == `ASL_LEN_DA_NOID;
                        state <= (accept && is_da) ? asl_pkg::ASL_EXEC : asl_pkg::ASL_IDLE;
                    end
                end
                asl_pkg::ASL_EXEC: begin
                    state <= asl_pkg::ASL_REPLY;
                end
                asl_pkg::ASL_REPLY: begin
                    // bytes arriving while the reply is sent are ignored
                    if (tx_take && tx_idx > `ASL_POS_LAST - (no_id ? `ASL_NOID_SKIP : 6'd0)) begin
                        state <= asl_pkg::ASL_IDLE;
                    end
                end
                default: state <= asl_pkg::ASL_IDLE;
            endcase
        end
    end

    // field snapshot keeps one reply self-consistent while software updates values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            snap_conc <= `ASL_RST_CONC;
            snap_stat <= 8'h00;
            snap_fail <= 8'h00;
            snap_id   <= 12'h000;
        end else if (state == asl_pkg::ASL_EXEC) begin
            snap_conc <= conc;
            snap_stat <= status_byte;
            snap_fail <= fail;
            snap_id   <= station_id;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reply byte at logical position; check characters follow the end marker
    always_comb begin
        case (pos)
            6'd0:  next_tx_byte = `ASL_BYTE_STX;
            6'd1:  next_tx_byte = `ASL_CH_M;
            6'd2:  next_tx_byte = `ASL_CH_D;
            6'd3:  next_tx_byte = `ASL_BYTE_ZERO;
            6'd4:  next_tx_byte = `ASL_CHAN_COUNT;
            6'd6:  next_tx_byte = dig(snap_id[11:8]);
            6'd7:  next_tx_byte = dig(snap_id[7:4]);
            6'd8:  next_tx_byte = dig(snap_id[3:0]);
            6'd10: next_tx_byte = sign(snap_conc.mant_neg);
            6'd11: next_tx_byte = dig(snap_conc.mant_bcd[15:12]);
            6'd12: next_tx_byte = dig(snap_conc.mant_bcd[11:8]);
            6'd13: next_tx_byte = dig(snap_conc.mant_bcd[7:4]);
            6'd14: next_tx_byte = dig(snap_conc.mant_bcd[3:0]);
            6'd15: next_tx_byte = sign(snap_conc.exp_neg);
            6'd16: next_tx_byte = dig(snap_conc.exp_bcd[7:4]);
            6'd17: next_tx_byte = dig(snap_conc.exp_bcd[3:0]);
            6'd19: next_tx_byte = hex_char(snap_stat[7:4]);
            6'd20: next_tx_byte = hex_char(snap_stat[3:0]);
            6'd22: next_tx_byte = hex_char(snap_fail[7:4]);
            6'd23: next_tx_byte = hex_char(snap_fail[3:0]);
            6'd5, 6'd9, 6'd18, 6'd21, 6'd27, 6'd36: next_tx_byte = `ASL_BYTE_SP;
            6'd37: next_tx_byte = `ASL_BYTE_ETX;
            6'd38: next_tx_byte = hex_char(tx_bcc[7:4]);
            6'd39: next_tx_byte = hex_char(tx_bcc[3:0]);
            default: next_tx_byte = `ASL_BYTE_ZERO;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx     <= '0;
            tx_idx <= 6'd0;
            tx_bcc <= `ASL_BCC_INIT;
        end else if (state == asl_pkg::ASL_EXEC) begin
            tx_idx <= 6'd0;
            tx_bcc <= `ASL_BCC_INIT;
        end else if (state == asl_pkg::ASL_REPLY && tx_take) begin
            if (pos <= `ASL_POS_LAST) begin
                tx.valid <= 1'b1;
                tx.data  <= next_tx_byte;
                tx_idx   <= tx_idx + 6'd1;
                if (pos <= `ASL_POS_ETX) begin
                    tx_bcc <= tx_bcc ^ next_tx_byte;
                end
            end else begin
                tx.valid <= 1'b0;
            end
        end else if (tx_ready) begin
            tx.valid <= 1'b0;
        end
    end
endmodule : asl_responder

// ==== asl_responder_asserts.sv ====
// concurrent checks on the station link responder ports
`timescale 1ns/100ps
module asl_responder_asserts (
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [7:0]         paddr,
    input wire logic [31:0]        pwdata,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire asl_pkg::asl_byte_s rx,
    input wire asl_pkg::asl_byte_s tx,
    input wire logic               tx_ready
);
    logic [1:0] post;
    logic       start_next;
    logic       acc;
    logic       rd;
    assign acc = tx.valid && tx_ready;
    assign rd  = psel && penable && !pwrite;
    // end byte never occurs inside ascii fields, so it marks the frame tail
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            post       <= 2'd0;
            start_next <= 1'b1;
        end else if (acc) begin
            post       <= (post != 2'd0) ? post - 2'd1 : ((tx.data == 8'h03) ? 2'd2 : 2'd0);
            start_next <= (post == 2'd1);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_reply_start: assert property (acc && start_next |-> tx.data == 8'h02)
        else $error("reply does not open with start byte");
    a_check_hex: assert property (acc && post != 2'd0 |-> tx.data inside {[8'h30:8'h39], [8'h41:8'h46]})
        else $error("check character not upper hex");
    a_tx_stands: assert property (tx.valid && !tx_ready |=> tx.valid && $stable(tx.data))
        else $error("tx byte changed before accept");
    a_tx_ascii: assert property (acc && !start_next && post == 2'd0 |-> tx.data == 8'h03 || tx.data inside {[8'h20:8'h7E]})
        else $error("reply body byte not printable");
    a_status_low: assert property (rd && paddr == 8'h0C |-> prdata[0] == 1'b0 && prdata[5:4] == 2'b00)
        else $error("status bit 0 or unused bits set");
    a_mode_bits: assert property (rd && paddr == 8'h0C |-> prdata[3:2] == {prdata[9:8] == 2'd2, prdata[9:8] == 2'd1})
        else $error("zero or span bit disagrees with mode");
    a_fail_mask: assert property (rd && paddr == 8'h08 |-> (prdata & ~32'h0000_002B) == 32'h0)
        else $error("failure byte has unused bits");
    a_reset_quiet: assert property ($rose(presetn) |-> !tx.valid)
        else $error("tx active right after reset");
    c_reply: cover property (acc && start_next);
    c_stall: cover property (tx.valid && !tx_ready);
    c_bg: cover property (rd && paddr == 8'h0C && prdata[7]);
endmodule : asl_responder_asserts
bind asl_responder asl_responder_asserts asl_responder_asserts_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx(rx), .tx(tx), .tx_ready(tx_ready));

// ==== asl_host.sv ====
// remote logger model: frames commands onto rx, collects reply bytes from tx
`timescale 1ns/100ps
module asl_host (
    input  wire logic               pclk,
    input  wire logic               slow,
    output asl_pkg::asl_byte_s      rx,
    input  wire asl_pkg::asl_byte_s tx,
    output logic                    tx_ready
);
    logic [7:0] got [$];
    initial begin
        rx       = '0;
        tx_ready = 1'b0;
    end
    // slow mode stalls the uart every other cycle
    always @(posedge pclk) begin
        if (tx.valid && tx_ready) got.push_back(tx.data);
        tx_ready <= slow ? ~tx_ready : 1'b1;
    end
    function automatic logic [7:0] hx(input logic [3:0] n);
        return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
    endfunction : hx
    task automatic put(input logic [7:0] b);
        @(posedge pclk);
        rx <= '{valid: 1'b1, data: b};
        @(posedge pclk);
        rx <= '{valid: 1'b0, data: ~b}; // no stale byte on an idle line
    endtask : put
    task automatic send(input string s, input logic bad);
        logic [7:0] c;
        c = 8'h02 ^ 8'h03;
        foreach (s[i]) c ^= s[i];
        if (bad) c = ~c;
        put(8'h02);
        foreach (s[i]) put(s[i]);
        put(8'h03);
        put(hx(c[7:4]));
        put(hx(c[3:0]));
    endtask : send
endmodule : asl_host

// ==== ascii_station_link_responder_test.sv ====
// self-checking bench for the station link responder
`timescale 1ns/100ps
module ascii_station_link_responder_test;
    logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, tx_ready, slow, er;
    logic [7:0]         paddr;
    logic [31:0]        pwdata, prdata, rd;
    asl_pkg::asl_byte_s rx, tx;
    logic [7:0]         e [$];
    int                 failures, total_checks;
    asl_responder asl_responder_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx(rx), .tx(tx), .tx_ready(tx_ready));
    asl_host asl_host_inst (.pclk(pclk), .slow(slow), .rx(rx), .tx(tx), .tx_ready(tx_ready));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
        if (n >= 50) begin
            failures++;
            results();
        end
    endtask : apb
    // expected reply record, worked out from the register values
    task automatic build(input logic id, input logic [11:0] s, input logic [25:0] c, input logic [7:0] ss);
        logic [7:0] b;
        e = {8'h02, 8'h4D, 8'h44, 8'h30, 8'h31, 8'h20};
        if (id) e = {e, 8'h30 + s[11:8], 8'h30 + s[7:4], 8'h30 + s[3:0], 8'h20};
        e = {e, c[16] ? 8'h2D : 8'h2B, 8'h30 + c[15:12], 8'h30 + c[11:8], 8'h30 + c[7:4], 8'h30 + c[3:0]};
        e = {e, c[25] ? 8'h2D : 8'h2B, 8'h30 + c[24:21], 8'h30 + c[20:17], 8'h20};
        e = {e, asl_host_inst.hx(ss[7:4]), asl_host_inst.hx(ss[3:0]), 8'h20, 8'h32, 8'h42};
        e = {e, 8'h30, 8'h30, 8'h30, 8'h20};
        e = {e, 8'h30, 8'h30, 8'h30, 8'h30, 8'h30, 8'h30, 8'h30, 8'h30, 8'h20, 8'h03};
        b = 8'h00;
        foreach (e[i]) b ^= e[i];
        e = {e, asl_host_inst.hx(b[7:4]), asl_host_inst.hx(b[3:0])};
    endtask : build
    task automatic expect_reply();
        int n;
        n = 0;
        while (!(asl_host_inst.got.size() > 2 && asl_host_inst.got[asl_host_inst.got.size() - 3] === 8'h03)
               && n < 900) begin
            @(posedge pclk);
            n++;
        end
        repeat (20) @(posedge pclk);
        chk("reply length", 32'(asl_host_inst.got.size()), 32'(e.size()));
        foreach (e[i]) if (i < asl_host_inst.got.size()) chk("reply byte", asl_host_inst.got[i], e[i]);
        asl_host_inst.got.delete();
        if (n >= 900) begin
            failures++;
            results();
        end
    endtask : expect_reply
    task automatic quiet();
        repeat (50) @(posedge pclk);
        chk("no reply", 32'(asl_host_inst.got.size()), 32'h0);
    endtask : quiet
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        for (int a = 0; a < 4; a++) begin
            apb(1'b0, 8'(a * 4), 32'h0);
            chk("reset value", rd, 32'h0);
        end
        apb(1'b1, 8'h08, 32'hFF);
        apb(1'b0, 8'h08, 32'h0);
        chk("failure mask", rd, 32'h2B);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped error", er, 32'h1);
    endtask : t_regs
    task automatic t_da();
        apb(1'b1, 8'h00, 32'h0000_3097);
        apb(1'b1, 8'h04, 32'h000B_1234);
        slow <= 1'b1;
        asl_host_inst.send("DA097", 1'b0);
        build(1'b1, 12'h097, 26'h00B_1234, 8'h42);
        expect_reply();
        slow <= 1'b0;
        asl_host_inst.send("DA", 1'b0);
        build(1'b0, 12'h097, 26'h00B_1234, 8'h42);
        expect_reply();
    endtask : t_da
    task automatic t_modes();
        string s;
        string l;
        logic [1:0] m;
        apb(1'b1, 8'h00, 32'h0000_0843);
        s = "ST843 K";
        l = "KNMS";
        for (int i = 0; i < 4; i++) begin
            s[6] = l[i];
            m = (i == 0) ? 2'd2 : ((i == 1) ? 2'd1 : 2'd0);
            asl_host_inst.send(s, 1'b0);
            quiet();
            apb(1'b0, 8'h0C, 32'h0);
            chk("mode field", rd[9:8], m);
            chk("mode bits", rd[3:2], {m == 2'd2, m == 2'd1});
        end
        chk("background bit", rd[7], 1'b1);
        asl_host_inst.send("DA843", 1'b0);
        build(1'b1, 12'h843, 26'h00B_1234, 8'h80);
        expect_reply();
        apb(1'b1, 8'h0C, 32'h1);
        apb(1'b0, 8'h0C, 32'h0);
        chk("background cleared", rd[7], 1'b0);
    endtask : t_modes
    task automatic t_drops();
        string s;
        logic [7:0] d;
        apb(1'b0, 8'h0C, 32'h0);
        d = rd[23:16];
        s = "DA";
        // 130 characters: a length counter that wrapped would see a bare request here
        repeat (128) s = {s, "0"};
        asl_host_inst.send("DA843", 1'b1);
        asl_host_inst.send("DA097", 1'b0);
        asl_host_inst.send(s, 1'b0);
        quiet();
        apb(1'b0, 8'h0C, 32'h0);
        chk("drop count", rd[23:16], d + 8'h03);
        asl_host_inst.send("DA843", 1'b0);
        build(1'b1, 12'h843, 26'h00B_1234, 8'h00);
        expect_reply();
    endtask : t_drops
    initial begin
        {presetn, psel, penable, pwrite, slow} = 5'b0;
        paddr        = 8'h00;
        pwdata       = 32'h0;
        failures     = 0;
        total_checks = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_da();
        t_modes();
        t_drops();
        results();
    end
endmodule : ascii_station_link_responder_test
